// >>> hw/ccrs_core_regs.sv
// Summary of operation
// [RQ1] alu does 4-bit add, compare, and, or and single-bit work
// [RQ2] accumulator is a 4-bit operand and result register
// [RQ3] add memory with carry sets carry on carry out
// [RQ4] add immediate and add memory leave carry untouched
// [RQ5] rotate right moves accumulator bit 0 into carry
// [RQ6] rotate right puts old carry into bit 3, shifts others down
// [RQ7] carry set forces carry to 1, carry clear forces 0
// [RQ8] auxiliary nibble is 4 bits, pairs with accumulator for bytes
// [RQ9] pair register is 8 bits: aux high nibble, accumulator low
// [RQ10] pair register is not reset; software loads it
// [RQ11] table pointer and accumulator form a 7-bit in-page address
// [RQ12] table read with upper fetch set loads rom bits into pointer
// [RQ13] table read with upper fetch clear keeps the table pointer
// [RQ14] upper fetch flag set and cleared by ops, zero after reset
// [RQ15] table pointer is not reset; software loads it
// [RQ16] interrupt entry, calls and table reads push the counter
// [RQ17] return stack has eight entries; ninth push overwrites
// [RQ18] software keeps interrupts, table reads and calls within eight
// [RQ19] 3-bit stack index tracks nesting, readable into accumulator
// [RQ20] index is 7 after reset, incremented before each push
// [RQ21] return reloads counter from indexed entry, then decrements
// [RQ22] save register captures pointer, carry, skip, acc, aux
// [RQ23] calls and table reads leave the save register alone
// [RQ24] skip flag decides skipping and survives interrupts
// [RQ25] interrupt return restores pointer, carry, skip, acc, aux
// [RQ26] saved data pointer has group, file and digit fields
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module ccrs_core_regs
   import ccrs_pkg::*;
(
   input  wire logic                    clk_sys_in,
   input  wire logic                    rst_n_in,
   input  wire ccrs_req_type            req_in,
   input  wire logic                    skip_cond_in,
   input  wire ccrs_bus_type            bus_in,
   output logic      [7:0]              bus_rdata_out,
   output logic      [3:0]              acc_out,
   output logic                         carry_out,
   output logic      [3:0]              aux_out,
   output logic      [7:0]              pair_out,
   output logic      [2:0]              tptr_out,
   output logic                         upper_fetch_out,
   output logic                         skip_out,
   output logic      [`CCRS_IDX_W-1:0]  stack_index_out,
   output logic      [6:0]              rom_addr_out,
   output logic      [3:0]              mem_wdata_out,
   output logic                         mem_we_out,
   output logic      [`CCRS_CNT_W-1:0]  ret_counter_out,
   output logic                         ret_valid_out,
   output ccrs_ram_ptr_type             ram_ptr_out,
   output logic                         ram_ptr_valid_out
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]    acc;
      logic          carry;
      logic [3:0]    aux;
      logic [7:0]    pair;
      logic [2:0]    tptr;
      logic          upf;
      logic          skip;
      ccrs_save_type save;
      logic [7:0]    rdata;
      logic [3:0]    mem;
      logic          mem_we;
      logic          ret_valid;
      logic          ptr_valid;
      ccrs_ram_ptr_type ptr;
   } ccrs_core_type;

   ccrs_core_type st_q;
   ccrs_core_type st_d;

   ccrs_alu_type           alu;
   logic                   push;
   logic                   pop;
   logic [`CCRS_IDX_W-1:0] idx;
   logic [`CCRS_CNT_W-1:0] top;
   logic                   run;

   assign run = req_in.valid;

   // ---------------------------------------------------------------
   // alu and return stack
   // ---------------------------------------------------------------
   ccrs_alu u_alu (
      .op_in      (req_in.op),
      .acc_in     (st_q.acc),
      .carry_in   (st_q.carry),
      .mem_in     (req_in.mem),
      .imm_in     (req_in.imm),
      .bit_sel_in (req_in.bit_sel),
      .res_out    (alu)
   );

   always_comb begin
      push = 1'b0;
      pop  = 1'b0;
      if (run) begin
         case (req_in.op)
            call_op, call_indirect_op, page_two_call_op,
            table_read_op, int_entry_op: push = 1'b1;           // RQ16
            return_op, int_return_op:    pop  = 1'b1;           // RQ21
            default: begin
               push = 1'b0;
               pop  = 1'b0;
            end
         endcase
      end
   end

   ccrs_stack u_stack (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .push_in    (push),
      .pop_in     (pop),
      .counter_in (req_in.counter),
      .index_out  (idx),
      .top_out    (top)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d           = st_q;
      st_d.mem_we    = 1'b0;
      st_d.ret_valid = pop;
      st_d.ptr_valid = 1'b0;
      st_d.rdata     = 8'h00;

      // register port read, answered next cycle
      if (bus_in.rd) begin
         case (bus_in.addr)
            `CCRS_OFS_ACC:   st_d.rdata = {4'h0, st_q.acc};
            `CCRS_OFS_AUX:   st_d.rdata = {4'h0, st_q.aux};
            `CCRS_OFS_PAIR:  st_d.rdata = st_q.pair;
            `CCRS_OFS_TPTR:  st_d.rdata = {5'h00, st_q.tptr};
            `CCRS_OFS_FLAGS: st_d.rdata = {5'h00, st_q.skip, st_q.upf, st_q.carry};
            `CCRS_OFS_INDEX: st_d.rdata = {5'h00, idx};           // RQ19
            `CCRS_OFS_SAVE:  st_d.rdata = {st_q.save.aux, st_q.save.acc};
            default:         st_d.rdata = 8'h00;
         endcase
      end

      // register port write, yields to a sequencer op
      if (bus_in.wr && !run) begin
         case (bus_in.addr)
            `CCRS_OFS_ACC:  st_d.acc  = bus_in.wdata[3:0];
            `CCRS_OFS_AUX:  st_d.aux  = bus_in.wdata[3:0];
            `CCRS_OFS_PAIR: st_d.pair = bus_in.wdata;
            `CCRS_OFS_TPTR: st_d.tptr = bus_in.wdata[2:0];
            `CCRS_OFS_FLAGS: begin
               st_d.carry = bus_in.wdata[`CCRS_FLG_CARRY];
               st_d.upf   = bus_in.wdata[`CCRS_FLG_UPF];
               st_d.skip  = bus_in.wdata[`CCRS_FLG_SKIP];
            end
            default: st_d.rdata = st_d.rdata;
         endcase
      end

      // sequencer ops
      if (run) begin
         // skip decision for the following instruction
         st_d.skip = alu.skip | skip_cond_in;                     // RQ24
         if (alu.acc_we) begin
            st_d.acc = alu.acc;                                   // RQ2
         end
         if (alu.carry_we) begin
            st_d.carry = alu.carry;                               // RQ3
         end
         st_d.mem    = alu.mem;
         st_d.mem_we = alu.mem_we;
         case (req_in.op)
            load_imm_op:   st_d.acc = req_in.imm;                 // RQ2
            mem_to_acc_op: st_d.acc = req_in.mem;                 // RQ2
            acc_to_aux_op: st_d.aux = st_q.acc;                   // RQ8
            aux_to_acc_op: st_d.acc = st_q.aux;                   // RQ8
            pair_load_op:  st_d.pair = {st_q.aux, st_q.acc};      // RQ9
            pair_unload_op: begin
               st_d.aux = st_q.pair[7:4];                         // RQ9
               st_d.acc = st_q.pair[3:0];                         // RQ9
            end
            acc_to_tptr_op: st_d.tptr = st_q.acc[2:0];
            table_read_op: begin
               if (st_q.upf) begin
                  st_d.tptr = {1'b0, req_in.rom_word[9:8]};       // RQ12
               end
               st_d.acc = req_in.rom_word[3:0];
               st_d.aux = req_in.rom_word[7:4];
            end
            upper_fetch_set_op:   st_d.upf = 1'b1;                // RQ14
            upper_fetch_clear_op: st_d.upf = 1'b0;                // RQ14
            stack_index_read_op:  st_d.acc = {1'b0, idx};         // RQ19
            int_entry_op: begin
               st_d.save.ram_ptr = req_in.ram_ptr;                // RQ26
               st_d.save.carry   = st_q.carry;                    // RQ22
               st_d.save.skip    = st_q.skip;                     // RQ24
               st_d.save.acc     = st_q.acc;                      // RQ22
               st_d.save.aux     = st_q.aux;                      // RQ22
               st_d.skip         = 1'b0;
            end
            int_return_op: begin
               st_d.ptr       = st_q.save.ram_ptr;                // RQ25
               st_d.ptr_valid = 1'b1;                             // RQ25
               st_d.carry     = st_q.save.carry;                  // RQ25
               st_d.skip      = st_q.save.skip;                   // RQ25
               st_d.acc       = st_q.save.acc;                    // RQ25
               st_d.aux       = st_q.save.aux;                    // RQ25
            end
            default: st_d.ptr = st_q.ptr;                         // RQ23
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         st_q.acc       <= `CCRS_NIB_RST;
         st_q.carry     <= 1'b0;
         st_q.aux       <= `CCRS_NIB_RST;
         st_q.upf       <= `CCRS_UPF_RST;                         // RQ14
         st_q.skip      <= 1'b0;
         st_q.save      <= '0;
         st_q.rdata     <= 8'h00;
         st_q.mem       <= `CCRS_NIB_RST;
         st_q.mem_we    <= 1'b0;
         st_q.ret_valid <= 1'b0;
         st_q.ptr_valid <= 1'b0;
         st_q.ptr       <= '0;
         st_q.pair      <= st_q.pair;                             // RQ10
         st_q.tptr      <= st_q.tptr;                             // RQ15
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign bus_rdata_out     = st_q.rdata;
   assign acc_out           = st_q.acc;
   assign carry_out         = st_q.carry;
   assign aux_out           = st_q.aux;
   assign pair_out          = st_q.pair;
   assign tptr_out          = st_q.tptr;
   assign upper_fetch_out   = st_q.upf;
   assign skip_out          = st_q.skip;
   assign stack_index_out   = idx;
   assign rom_addr_out      = {st_q.tptr, st_q.acc};              // RQ11
   assign mem_wdata_out     = st_q.mem;
   assign mem_we_out        = st_q.mem_we;
   assign ret_counter_out   = top;
   assign ret_valid_out     = st_q.ret_valid;
   assign ram_ptr_out       = st_q.ptr;
   assign ram_ptr_valid_out = st_q.ptr_valid;
endmodule

// >>> include/ccrs_defines.svh
`ifndef CCRS_DEFINES_SVH
`define CCRS_DEFINES_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define CCRS_CNT_W      13
`define CCRS_GROUP_W    2
`define CCRS_FILE_W     3
`define CCRS_DIGIT_W    4
`define CCRS_DEPTH      8
`define CCRS_IDX_W      3
`define CCRS_ADDR_W     4
`define CCRS_ROM_W      10

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CCRS_IDX_RST    3'h7
`define CCRS_UPF_RST    1'b0
`define CCRS_NIB_RST    4'h0

// ---------------------------------------------------------------
// register offsets and field positions
// ---------------------------------------------------------------
`define CCRS_OFS_ACC    4'h0
`define CCRS_OFS_AUX    4'h1
`define CCRS_OFS_PAIR   4'h2
`define CCRS_OFS_TPTR   4'h3
`define CCRS_OFS_FLAGS  4'h4
`define CCRS_OFS_INDEX  4'h5
`define CCRS_OFS_SAVE   4'h6
`define CCRS_FLG_CARRY  0
`define CCRS_FLG_UPF    1
`define CCRS_FLG_SKIP   2

`endif

// >>> include/ccrs_pkg.sv
package ccrs_pkg;
`include "ccrs_defines.svh"

   typedef enum logic [4:0] {
      nop_op, add_imm_op, add_memory_op, add_memory_carry_op, compare_op,
      and_op, or_op, bit_set_op, bit_clear_op, bit_test_op, rotate_right_op,
      carry_set_op, carry_clear_op, load_imm_op, mem_to_acc_op, acc_to_aux_op,
      aux_to_acc_op, pair_load_op, pair_unload_op, acc_to_tptr_op,
      table_read_op, branch_indirect_op, call_op, call_indirect_op,
      page_two_call_op, return_op, int_entry_op, int_return_op,
      upper_fetch_set_op, upper_fetch_clear_op, stack_index_read_op
   } ccrs_op_type;

   typedef struct packed {
      logic [`CCRS_GROUP_W-1:0] group;
      logic [`CCRS_FILE_W-1:0]  file;
      logic [`CCRS_DIGIT_W-1:0] digit;
   } ccrs_ram_ptr_type;

   typedef struct packed {
      logic                   valid;
      ccrs_op_type            op;
      logic [3:0]             imm;
      logic [3:0]             mem;
      logic [1:0]             bit_sel;
      logic [`CCRS_ROM_W-1:0] rom_word;
      logic [`CCRS_CNT_W-1:0] counter;
      ccrs_ram_ptr_type       ram_ptr;
   } ccrs_req_type;

   typedef struct packed {
      logic [3:0] acc;
      logic       acc_we;
      logic       carry;
      logic       carry_we;
      logic [3:0] mem;
      logic       mem_we;
      logic       skip;
   } ccrs_alu_type;

   typedef struct packed {
      ccrs_ram_ptr_type ram_ptr;
      logic             carry;
      logic             skip;
      logic [3:0]       acc;
      logic [3:0]       aux;
   } ccrs_save_type;

   typedef struct packed {
      logic                    wr;
      logic                    rd;
      logic [`CCRS_ADDR_W-1:0] addr;
      logic [7:0]              wdata;
   } ccrs_bus_type;

endpackage

// >>> hw/ccrs_alu.sv
`timescale 1ns/1ps
module ccrs_alu
   import ccrs_pkg::*;
(
   input  wire ccrs_op_type  op_in,
   input  wire logic [3:0]   acc_in,
   input  wire logic         carry_in,
   input  wire logic [3:0]   mem_in,
   input  wire logic [3:0]   imm_in,
   input  wire logic [1:0]   bit_sel_in,
   output ccrs_alu_type      res_out
);
   logic [4:0] sum;
   logic [3:0] mask;

   always_comb begin
      sum  = 5'h00;
      mask = 4'h1 << bit_sel_in;
      res_out = '0;
      case (op_in)
         add_imm_op: begin
            sum = {1'b0, acc_in} + {1'b0, imm_in};
            res_out.acc    = sum[3:0];                          // RQ4
            res_out.acc_we = 1'b1;
         end
         add_memory_op: begin
            sum = {1'b0, acc_in} + {1'b0, mem_in};
            res_out.acc    = sum[3:0];                          // RQ4
            res_out.acc_we = 1'b1;
         end
         add_memory_carry_op: begin
            sum = {1'b0, acc_in} + {1'b0, mem_in} + {4'h0, carry_in};
            res_out.acc      = sum[3:0];
            res_out.acc_we   = 1'b1;
            res_out.carry    = sum[4];                          // RQ3
            res_out.carry_we = 1'b1;
         end
         compare_op: res_out.skip = (acc_in == mem_in);          // RQ1
         and_op: begin
            res_out.acc    = acc_in & mem_in;                   // RQ1
            res_out.acc_we = 1'b1;
         end
         or_op: begin
            res_out.acc    = acc_in | mem_in;                   // RQ1
            res_out.acc_we = 1'b1;
         end
         bit_set_op: begin
            res_out.mem    = mem_in | mask;                     // RQ1
            res_out.mem_we = 1'b1;
         end
         bit_clear_op: begin
            res_out.mem    = mem_in & ~mask;                    // RQ1
            res_out.mem_we = 1'b1;
         end
         bit_test_op: res_out.skip = ((mem_in & mask) == 4'h0);  // RQ1
         rotate_right_op: begin
            res_out.acc      = {carry_in, acc_in[3:1]};         // RQ6
            res_out.acc_we   = 1'b1;
            res_out.carry    = acc_in[0];                       // RQ5
            res_out.carry_we = 1'b1;
         end
         carry_set_op: begin
            res_out.carry    = 1'b1;                            // RQ7
            res_out.carry_we = 1'b1;
         end
         carry_clear_op: begin
            res_out.carry    = 1'b0;                            // RQ7
            res_out.carry_we = 1'b1;
         end
         default: res_out = '0;
      endcase
   end
endmodule

// >>> hw/ccrs_stack.sv
`timescale 1ns/1ps
module ccrs_stack
   import ccrs_pkg::*;
(
   input  wire logic                   clk_sys_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   push_in,
   input  wire logic                   pop_in,
   input  wire logic [`CCRS_CNT_W-1:0] counter_in,
   output logic      [`CCRS_IDX_W-1:0] index_out,
   output logic      [`CCRS_CNT_W-1:0] top_out
);
   typedef struct packed {
      logic [`CCRS_IDX_W-1:0]                      idx;
      logic [`CCRS_CNT_W-1:0]                      top;
      logic [`CCRS_DEPTH-1:0][`CCRS_CNT_W-1:0]     ent;
   } ccrs_stk_type;

   ccrs_stk_type st_q;
   ccrs_stk_type st_d;

   always_comb begin
      st_d = st_q;
      if (push_in) begin
         st_d.idx = st_q.idx + 3'h1;                            // RQ20
         st_d.ent[st_d.idx] = counter_in;                       // RQ17
      end else if (pop_in) begin
         st_d.top = st_q.ent[st_q.idx];                         // RQ21
         st_d.idx = st_q.idx - 3'h1;                            // RQ21
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         st_q.idx <= `CCRS_IDX_RST;                             // RQ20
         st_q.top <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign index_out = st_q.idx;                                 // RQ19
   assign top_out   = st_q.top;
endmodule

// >>> testbench/ccrs_seq_model.sv
`timescale 1ns/1ps
module ccrs_seq_model
   import ccrs_pkg::*;
(
   input  wire logic   clk_sys_in,
   output ccrs_req_type req_out
);
   // ---------------------------------------------------------------
   // sequencer side: one op per call, valid for exactly one cycle
   // ---------------------------------------------------------------
   initial req_out = '0;

   // caller keeps nesting within eight unless overflow is wanted
   task automatic issue(input ccrs_op_type o, input logic [3:0] m, input logic [9:0] r,
                        input logic [12:0] c, input ccrs_ram_ptr_type p);
      @(posedge clk_sys_in);
      req_out <= '{valid:1'b1, op:o, imm:m, mem:m, bit_sel:2'h0, rom_word:r, counter:c, ram_ptr:p};
      @(posedge clk_sys_in);
      req_out <= {1'b0, ~req_out[$bits(ccrs_req_type)-2:0]};
   endtask
endmodule

// >>> testbench/ccrs_core_regs_checker.sv
`timescale 1ns/1ps
module ccrs_core_regs_checker
   import ccrs_pkg::*;
(
   input wire logic                   clk_sys_in,
   input wire logic                   rst_n_in,
   input wire ccrs_req_type           req_in,
   input wire logic [3:0]             acc_out,
   input wire logic                   carry_out,
   input wire logic [2:0]             tptr_out,
   input wire logic                   upper_fetch_out,
   input wire logic [`CCRS_IDX_W-1:0] stack_index_out,
   input wire logic [6:0]             rom_addr_out,
   input wire logic                   ret_valid_out
);
   // ---------------------------------------------------------------
   // op relations
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_push;
      req_in.valid && (req_in.op == call_op || req_in.op == table_read_op || req_in.op == int_entry_op);
   endsequence
   sequence s_pop;
      req_in.valid && req_in.op == return_op;
   endsequence
   sequence s_popped;
      ret_valid_out && stack_index_out == $past(stack_index_out) - 3'h1;
   endsequence

   carry_set_a: assert property (req_in.valid && req_in.op == carry_set_op |=> carry_out)
      else $error("carry not set");
   carry_clear_a: assert property (req_in.valid && req_in.op == carry_clear_op |=> !carry_out)
      else $error("carry not cleared");
   add_carry_keep_a: assert property (req_in.valid && (req_in.op == add_imm_op || req_in.op == add_memory_op)
      |=> $stable(carry_out)) else $error("carry changed by plain add");
   amc_carry_a: assert property (req_in.valid && req_in.op == add_memory_carry_op &&
      ({1'b0, acc_out} + {1'b0, req_in.mem} + {4'h0, carry_out}) >= 5'h10 |=> carry_out)
      else $error("carry out lost");
   rotate_right_a: assert property (req_in.valid && req_in.op == rotate_right_op |=>
      carry_out == $past(acc_out[0]) && acc_out == {$past(carry_out), $past(acc_out[3:1])})
      else $error("rotate wrong");
   push_index_a: assert property (s_push |=> stack_index_out == $past(stack_index_out) + 3'h1)
      else $error("push index wrong");
   pop_index_a: assert property (s_pop |=> s_popped) else $error("pop wrong");
   table_addr_a: assert property (req_in.valid && req_in.op == table_read_op |->
      rom_addr_out == {tptr_out, acc_out}) else $error("table address wrong");
   upf_set_a: assert property (req_in.valid && req_in.op == upper_fetch_set_op |=> upper_fetch_out)
      else $error("upper fetch not set");
   tptr_keep_a: assert property (req_in.valid && req_in.op == table_read_op && !upper_fetch_out
      |=> $stable(tptr_out)) else $error("table pointer changed");
   tptr_load_a: assert property (req_in.valid && req_in.op == table_read_op && upper_fetch_out
      |=> tptr_out == {1'b0, $past(req_in.rom_word[9:8])}) else $error("table pointer not loaded");
endmodule

bind ccrs_core_regs ccrs_core_regs_checker ccrs_core_regs_checker_i (
   .clk_sys_in      (clk_sys_in),
   .rst_n_in        (rst_n_in),
   .req_in          (req_in),
   .acc_out         (acc_out),
   .carry_out       (carry_out),
   .tptr_out        (tptr_out),
   .upper_fetch_out (upper_fetch_out),
   .stack_index_out (stack_index_out),
   .rom_addr_out    (rom_addr_out),
   .ret_valid_out   (ret_valid_out)
);

// >>> testbench/ccrs_core_regs_test.sv
`timescale 1ns/1ps
module ccrs_core_regs_test
   import ccrs_pkg::*;
;
   // ---------------------------------------------------------------
   // bench signals and design
   // ---------------------------------------------------------------
   logic             clk_sys_in = 1'b0;
   logic             rst_n_in   = 1'b0;
   ccrs_req_type     req;
   ccrs_bus_type     bus        = '0;
   ccrs_ram_ptr_type ptr        = '0;
   ccrs_ram_ptr_type rptr;
   logic [7:0]       rdata;
   logic [6:0]       rom_addr;
   logic [2:0]       idx;
   logic [12:0]      ret_cnt;
   logic             ret_v;
   logic             rptr_v;
   logic [3:0]       mwd;
   logic             mwe;
   int               err_total  = 0;
   int               tests_run  = 0;
   int               cycles     = 0;

   always #2 clk_sys_in = ~clk_sys_in;

   ccrs_seq_model ccrs_seq_model_i (.clk_sys_in(clk_sys_in), .req_out(req));

   ccrs_core_regs ccrs_core_regs_i (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req), .skip_cond_in(1'b0), .bus_in(bus),
      .bus_rdata_out(rdata), .acc_out(), .carry_out(), .aux_out(), .pair_out(), .tptr_out(),
      .upper_fetch_out(), .skip_out(), .stack_index_out(idx), .rom_addr_out(rom_addr),
      .mem_wdata_out(mwd), .mem_we_out(mwe), .ret_counter_out(ret_cnt), .ret_valid_out(ret_v),
      .ram_ptr_out(rptr), .ram_ptr_valid_out(rptr_v)
   );

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reset;
      rst_n_in <= 1'b0;
      repeat (16) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      bus <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
      @(posedge clk_sys_in);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys_in);
      bus <= '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00};
      @(posedge clk_sys_in);
      bus.rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp});
   endtask

   task automatic op(input ccrs_op_type o, input logic [3:0] m, input logic [9:0] r, input logic [12:0] c);
      ccrs_seq_model_i.issue(o, m, r, c, ptr);
      #1;
   endtask

   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         stop_test();
      end
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      reset();
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      rd(4'h4, 8'h00);
      rd(4'h5, 8'h07);
      rd(4'h6, 8'h00);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00);
      $display("reset values done");
      op(carry_set_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h4, 8'h01);
      op(carry_clear_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h4, 8'h00);
      wr(4'h0, 8'h0f);
      op(add_imm_op, 4'h1, 10'h000, 13'h0000);
      rd(4'h0, 8'h00);
      rd(4'h4, 8'h00);
      op(carry_set_op, 4'h0, 10'h000, 13'h0000);
      wr(4'h0, 8'h02);
      op(add_memory_op, 4'h3, 10'h000, 13'h0000);
      rd(4'h0, 8'h05);
      rd(4'h4, 8'h01);
      wr(4'h4, 8'h00);
      wr(4'h0, 8'h0f);
      op(add_memory_carry_op, 4'h1, 10'h000, 13'h0000);
      rd(4'h0, 8'h00);
      rd(4'h4, 8'h01);
      wr(4'h4, 8'h00);
      wr(4'h0, 8'h05);
      op(rotate_right_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h0, 8'h02);
      rd(4'h4, 8'h01);
      op(rotate_right_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h0, 8'h09);
      wr(4'h0, 8'h07);
      op(compare_op, 4'h7, 10'h000, 13'h0000);
      rd(4'h4, 8'h04);
      op(stack_index_read_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h0, 8'h07);
      op(and_op, 4'h6, 10'h000, 13'h0000);
      rd(4'h0, 8'h06);
      op(bit_set_op, 4'h4, 10'h000, 13'h0000);
      chk({11'h000, mwe, mwd}, 16'h0015);
      $display("alu and carry done");
      wr(4'h1, 8'h0a);
      wr(4'h0, 8'h05);
      op(pair_load_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h2, 8'ha5);
      wr(4'h2, 8'h3c);
      op(pair_unload_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h0, 8'h0c);
      rd(4'h1, 8'h03);
      $display("pair register done");
      wr(4'h3, 8'h05);
      wr(4'h0, 8'h0b);
      #1;
      chk({9'h000, rom_addr}, 16'h005b);
      op(table_read_op, 4'h0, 10'h3ab, 13'h0000);
      rd(4'h3, 8'h05);
      rd(4'h5, 8'h00);
      op(upper_fetch_set_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h4, 8'h02);
      op(table_read_op, 4'h0, 10'h2cd, 13'h0000);
      rd(4'h3, 8'h02);
      rd(4'h5, 8'h01);
      op(upper_fetch_clear_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h4, 8'h00);
      $display("table read done");
      reset();
      rd(4'h5, 8'h07);
      for (int i = 0; i < 9; i++) begin
         op(call_op, 4'h0, 10'h000, 13'h0100 + 13'(i));
         chk({13'h0000, idx}, 16'(i % 8));
      end
      for (int i = 0; i < 8; i++) begin
         op(return_op, 4'h0, 10'h000, 13'h0000);
         chk({15'h0000, ret_v}, 16'h0001);
         chk({3'h0, ret_cnt}, (i == 0) ? 16'h0108 : 16'(16'h0108 - i));
         chk({13'h0000, idx}, 16'(7 - i));
      end
      $display("return stack done");
      wr(4'h0, 8'h03);
      wr(4'h1, 8'h06);
      wr(4'h4, 8'h05);
      ptr = '{group:2'h1, file:3'h2, digit:4'h9};
      op(int_entry_op, 4'h0, 10'h000, 13'h0055);
      rd(4'h6, 8'h63);
      ptr = '{group:2'h2, file:3'h5, digit:4'h6};
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h00);
      wr(4'h4, 8'h00);
      op(call_op, 4'h0, 10'h000, 13'h0077);
      op(return_op, 4'h0, 10'h000, 13'h0000);
      rd(4'h6, 8'h63);
      op(int_return_op, 4'h0, 10'h000, 13'h0000);
      chk({15'h0000, rptr_v}, 16'h0001);
      chk({7'h00, rptr}, 16'h00a9);
      rd(4'h0, 8'h03);
      rd(4'h1, 8'h06);
      rd(4'h4, 8'h05);
      $display("interrupt save done");
      stop_test();
   end
endmodule
